// [hdl/pbss_pkg.sv]
// Package for the pipelined burst synchronous SRAM core
`default_nettype none
package pbss_pkg;
    localparam int PBSS_ADDR_W = 18;
    localparam int PBSS_DATA_W = 32;
    localparam int PBSS_LANES = 4;
    localparam int PBSS_DEPTH = 262144;
    localparam int PBSS_CNT_W = 2;
    localparam logic [1:0] PBSS_CNT_RST = 2'h0;
    localparam logic [3:0] PBSS_ALL_LANES = 4'hF;
    localparam logic [3:0] PBSS_NO_LANES = 4'h0;
    localparam logic [17:0] PBSS_ADDR_RST = 18'h0_0000;
    localparam logic [31:0] PBSS_DATA_RST = 32'h0000_0000;
    // Read pipeline: address edge, array register, output register
    localparam int PBSS_RD_LAT = 3;

    typedef logic [PBSS_ADDR_W-1:0] pbss_addr_t;
    typedef logic [PBSS_DATA_W-1:0] pbss_data_t;

    // Synchronous control pins, all sampled on the rising clock edge
    typedef struct packed {
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic chip_sel_primary_n;
        logic chip_sel_expand_hi;
        logic chip_sel_expand_lo_n;
        logic byte_lane3_sel_n;
        logic byte_lane2_sel_n;
        logic byte_lane1_sel_n;
        logic byte_lane0_sel_n;
        logic byte_write_en_n;
        logic all_bytes_write_n;
    } pbss_ctrl_s;

    localparam pbss_ctrl_s PBSS_CTRL_IDLE = '{
        processor_addr_strobe_n: 1'b1, controller_addr_strobe_n: 1'b1,
        burst_advance_n: 1'b1, chip_sel_primary_n: 1'b1,
        chip_sel_expand_hi: 1'b0, chip_sel_expand_lo_n: 1'b1,
        byte_lane3_sel_n: 1'b1, byte_lane2_sel_n: 1'b1,
        byte_lane1_sel_n: 1'b1, byte_lane0_sel_n: 1'b1,
        byte_write_en_n: 1'b1, all_bytes_write_n: 1'b1};
endpackage
`default_nettype wire

// [hdl/pbss_mem.sv]
// Storage array with byte-lane writes and registered read data
`default_nettype none
module pbss_mem #(
    parameter int DEPTH = pbss_pkg::PBSS_DEPTH,
    parameter int AW = pbss_pkg::PBSS_ADDR_W,
    parameter int LANES = pbss_pkg::PBSS_LANES
) (
    // Clock
    input wire logic mclk,
    // Access port
    input wire logic [AW-1:0] addr,
    input wire logic [LANES-1:0] we,
    input wire logic [8*LANES-1:0] wdata,
    output logic [8*LANES-1:0] rdata
);
    logic [8*LANES-1:0] mem_q [DEPTH];
    logic [8*LANES-1:0] rdata_q;

    if (DEPTH > (1 << AW) || DEPTH < 4) begin : g_bad_depth
        $error("pbss_mem: depth does not fit the address width");
    end

    // Self-timed write completes inside the cycle it was taken
    always_ff @(posedge mclk) begin
        for (int i = 0; i < LANES; i++) begin
            if (we[i]) begin
                mem_q[addr][8*i +: 8] <= wdata[8*i +: 8];
            end
        end
        rdata_q <= mem_q[addr];
    end

    assign rdata = rdata_q;
endmodule // pbss_mem
`default_nettype wire

// [hdl/pbss_core.sv]
// Pipelined burst synchronous SRAM core with double-cycle deselect
// Summary of operation
// - Register all synchronous inputs on rising edge.
// - Array of 262144 words, 32 bits, common data.
// - Capture address only when a strobe is low.
// - Address latched when strobe low and selected.
// - Load low two address bits into counter.
// - Advance low steps the burst counter.
// - Writes registered, then completed self-timed.
// - Byte lane selects choose written lanes.
// - Lane write needs byte write enable low.
// - Global write low writes all four lanes.
// - Outputs stay driven one cycle after deselect.
// - Selected when primary low, hi high, lo low.
// - Processor strobe ignored when primary select high.
// - Burst read timing is three-one-one-one clocks.
// - Both strobes low: processor strobe wins.
// - Burst order strap: low linear, high interleaved.
// - Read data from previously presented address.
// - Output enable masked first clock after deselect.
`default_nettype none
module pbss_core
    import pbss_pkg::*;
#(
    parameter int DEPTH = pbss_pkg::PBSS_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Synchronous bus from the controller
    input wire pbss_pkg::pbss_ctrl_s ctrl,
    input wire pbss_pkg::pbss_addr_t addr,
    input wire pbss_pkg::pbss_data_t dq_i,
    // Data pins, three-signal form
    output pbss_pkg::pbss_data_t dq_o,
    output logic dq_oe,
    // Asynchronous output enable and burst order strap
    input wire logic output_en_n,
    input wire logic burst_order_lin_n
);
    import pbss_pkg::*;

    if (DEPTH != (1 << PBSS_ADDR_W)) begin : g_bad_depth
        $error("pbss_core: depth must match the 18-bit address");
    end

    // Input registers
    pbss_ctrl_s in_q;
    pbss_addr_t addr_in_q;
    pbss_data_t din_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            in_q <= PBSS_CTRL_IDLE;
            addr_in_q <= PBSS_ADDR_RST;
            din_q <= PBSS_DATA_RST;
        end else begin
            in_q <= ctrl;
            addr_in_q <= addr;
            din_q <= dq_i;
        end
    end

    // Asynchronous pins pass two flip-flops; strap caught after release
    logic [1:0] oe_sync_q, oe_sync_d;
    logic [1:0] mode_sync_q, mode_sync_d;
    logic mode_lin_q, mode_lin_d;
    // Settle count: the strap is taken at the third edge after release,
    // once the synchroniser holds the pin and not its reset value
    logic [1:0] mode_wait_q, mode_wait_d;

    always_comb begin
        oe_sync_d = {oe_sync_q[0], output_en_n};
        mode_sync_d = {mode_sync_q[0], burst_order_lin_n};
        mode_lin_d = mode_lin_q;
        mode_wait_d = mode_wait_q;
        if (mode_wait_q != 2'h3) begin
            mode_wait_d = 2'(mode_wait_q + 2'h1);
        end
        if (mode_wait_q == 2'h2) begin
            mode_lin_d = !mode_sync_q[1];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oe_sync_q <= 2'h3;
            mode_sync_q <= 2'h3;
            mode_lin_q <= 1'b0;
            mode_wait_q <= 2'h0;
        end else begin
            oe_sync_q <= oe_sync_d;
            mode_sync_q <= mode_sync_d;
            mode_lin_q <= mode_lin_d;
            mode_wait_q <= mode_wait_d;
        end
    end

    // Access decode
    logic sel, p_take, c_take, start;
    logic [3:0] lanes;
    logic active_q, active_d;
    pbss_addr_t base_q, base_d;
    logic [1:0] cnt_q, cnt_d;
    logic [1:0] lo_d, lo_q;
    pbss_addr_t acc_addr;
    logic acc_wr, acc_rd, first_d;
    logic [3:0] mem_we;

    always_comb begin
        sel = !in_q.chip_sel_primary_n && in_q.chip_sel_expand_hi
            && !in_q.chip_sel_expand_lo_n;
        p_take = !in_q.processor_addr_strobe_n
            && !in_q.chip_sel_primary_n;
        c_take = !in_q.controller_addr_strobe_n && !p_take;
        start = p_take || c_take;
        if (!in_q.all_bytes_write_n) begin
            lanes = PBSS_ALL_LANES;
        end else if (!in_q.byte_write_en_n) begin
            lanes = ~{in_q.byte_lane3_sel_n, in_q.byte_lane2_sel_n,
                      in_q.byte_lane1_sel_n, in_q.byte_lane0_sel_n};
        end else begin
            lanes = PBSS_NO_LANES;
        end
        active_d = active_q;
        base_d = base_q;
        cnt_d = cnt_q;
        if (start) begin
            active_d = sel;
            if (sel) begin
                base_d = addr_in_q;
                cnt_d = PBSS_CNT_RST;
            end
        end else if (active_q && !in_q.burst_advance_n) begin
            cnt_d = 2'(cnt_q + 2'h1);
        end
        if (mode_lin_q) begin
            lo_d = 2'(base_d[1:0] + cnt_d);
        end else begin
            lo_d = base_d[1:0] ^ cnt_d;
        end
        acc_addr = {base_d[PBSS_ADDR_W-1:2], lo_d};
        // The cycle that takes the processor strobe is always a read; later burst cycles can write
        acc_wr = active_d && !p_take && (lanes != PBSS_NO_LANES);
        acc_rd = active_d && !acc_wr;
        mem_we = acc_wr ? lanes : PBSS_NO_LANES;
        first_d = start && sel && !active_q;
    end

    pbss_data_t rd_data;

    pbss_mem #(
        .DEPTH(DEPTH),
        .AW(PBSS_ADDR_W),
        .LANES(PBSS_LANES)
    ) u_mem (
        .mclk(mclk),
        .addr(acc_addr),
        .we(mem_we),
        .wdata(din_q),
        .rdata(rd_data)
    );

    // Read pipeline and output drive
    logic rd1_q, rd1_d, out_v_q, out_v_d;
    logic desel1_q, desel1_d, hold_q, hold_d, mask1_q, mask1_d;
    pbss_data_t dq_q, dq_d;
    logic drive;

    always_comb begin
        rd1_d = acc_rd;
        out_v_d = rd1_q;
        desel1_d = start && !sel;
        hold_d = out_v_q && desel1_q;
        mask1_d = first_d;
        dq_d = rd1_q ? rd_data : dq_q;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            active_q <= 1'b0;
            base_q <= PBSS_ADDR_RST;
            cnt_q <= PBSS_CNT_RST;
            lo_q <= PBSS_CNT_RST;
            rd1_q <= 1'b0;
            out_v_q <= 1'b0;
            desel1_q <= 1'b0;
            hold_q <= 1'b0;
            mask1_q <= 1'b0;
            dq_q <= PBSS_DATA_RST;
        end else begin
            active_q <= active_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            lo_q <= lo_d;
            rd1_q <= rd1_d;
            out_v_q <= out_v_d;
            desel1_q <= desel1_d;
            hold_q <= hold_d;
            mask1_q <= mask1_d;
            dq_q <= dq_d;
        end
    end

    assign drive = (out_v_q || hold_q) && !mask1_q;
    assign dq_oe = drive && !oe_sync_q[1];
    assign dq_o = dq_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_last_word_desel;
        out_v_q ##0 desel1_q;
    endsequence

    a_read_latency: assert property (
        acc_rd |=> rd1_q ##1 out_v_q)
        else $error("read data not valid two edges after access");
    a_burst_step: assert property (
        active_q && !start && !in_q.burst_advance_n
        |=> cnt_q == 2'($past(cnt_q) + 2'h1))
        else $error("burst counter did not step on advance");
    a_burst_load: assert property (
        start && sel |=> cnt_q == 2'h0
        && lo_q == $past(addr_in_q[1:0]))
        else $error("burst counter not loaded from address");
    a_addr_hold: assert property (
        !(start && sel) |=> base_q == $past(base_q))
        else $error("address register changed without capture");
    a_chip_desel: assert property (
        start && !sel |=> !active_q ##1 !out_v_q)
        else $error("deselect did not end access");
    a_strobe_ignore: assert property (
        in_q.chip_sel_primary_n && in_q.controller_addr_strobe_n
        |=> active_q == $past(active_q) && base_q == $past(base_q))
        else $error("processor strobe acted with primary select high");
    a_global_write: assert property (
        !in_q.all_bytes_write_n && active_d && !p_take
        |-> mem_we == PBSS_ALL_LANES)
        else $error("global write did not cover all lanes");
    a_lane_enable: assert property (
        in_q.all_bytes_write_n && in_q.byte_write_en_n
        |-> mem_we == PBSS_NO_LANES)
        else $error("lane written without byte write enable");
    a_proc_first: assert property (
        p_take && sel |-> mem_we == PBSS_NO_LANES)
        else $error("controller strobe acted beside processor strobe");
    a_dcd_hold: assert property (
        s_last_word_desel |=> hold_q && !out_v_q)
        else $error("outputs not held one cycle after deselect");
    a_first_mask: assert property (
        first_d |=> !dq_oe)
        else $error("output enabled in first clock after deselect");
    a_burst_wrap: assert property (
        active_q && !start |-> acc_addr[PBSS_ADDR_W-1:2]
        == base_q[PBSS_ADDR_W-1:2])
        else $error("burst carried into upper address bits");
    a_linear_order: assert property (
        mode_lin_q && active_q && !start && !in_q.burst_advance_n
        |=> lo_q == 2'($past(lo_q) + 2'h1))
        else $error("linear burst order wrong");
    a_interleave_ord: assert property (
        !mode_lin_q && active_q |-> (lo_q ^ base_q[1:0]) == cnt_q)
        else $error("interleaved burst order wrong");
    a_strap_static: assert property (
        mode_wait_q == 2'h3 |=> $stable(mode_lin_q))
        else $error("burst order changed after capture");
endmodule // pbss_core
`default_nettype wire

// [tb/pbss_host.sv]
// Bus controller model that drives the burst SRAM core
`default_nettype none
module pbss_host
    import pbss_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Bus to the core
    output var pbss_pkg::pbss_ctrl_s ctrl,
    output var pbss_pkg::pbss_addr_t addr,
    output var pbss_pkg::pbss_data_t dq_i,
    // Data pins from the core
    input wire pbss_pkg::pbss_data_t dq_o,
    input wire logic dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ctrl = PBSS_CTRL_IDLE;
        addr = PBSS_ADDR_RST;
        dq_i = PBSS_DATA_RST;
    end

    function automatic pbss_ctrl_s sel_c();
        pbss_ctrl_s c;
        c = PBSS_CTRL_IDLE;
        c.chip_sel_primary_n = 1'b0;
        c.chip_sel_expand_hi = 1'b1;
        c.chip_sel_expand_lo_n = 1'b0;
        return c;
    endfunction

    // One controller-strobe write cycle, data with its controls
    task automatic wr(input pbss_addr_t a, input pbss_data_t d,
                      input logic [3:0] ln, input logic be, input logic gw);
        pbss_ctrl_s c;
        c = sel_c();
        c.controller_addr_strobe_n = 1'b0;
        {c.byte_lane3_sel_n, c.byte_lane2_sel_n, c.byte_lane1_sel_n,
         c.byte_lane0_sel_n} = ln;
        c.byte_write_en_n = be;
        c.all_bytes_write_n = gw;
        @(posedge mclk);
        ctrl <= c;
        addr <= a;
        dq_i <= d;
    endtask

    // Four-word read burst, then a deselect; returns six sampled cycles
    task automatic rd(input pbss_addr_t a, output pbss_data_t w [6],
                      output logic [5:0] oe);
        pbss_ctrl_s c;
        c = sel_c();
        c.processor_addr_strobe_n = 1'b0;
        @(posedge mclk);
        ctrl <= c;
        addr <= a;
        dq_i <= ~dq_i;
        for (int i = 1; i < 9; i++) begin
            c = PBSS_CTRL_IDLE;
            c.burst_advance_n = !(i < 4);
            if (i == 4) begin
                // Start with primary select high: a deselect
                c.controller_addr_strobe_n = 1'b0;
            end
            @(posedge mclk);
            ctrl <= c;
            // Undriven lines keep moving so stale values never match
            addr <= ~addr;
            dq_i <= ~dq_i;
            if (i > 2) begin
                @(negedge mclk);
                w[i-3] = dq_o;
                oe[i-3] = dq_oe;
            end
        end
    endtask
endmodule // pbss_host
`default_nettype wire

// [tb/test_pipelined_burst_sync_sram.sv]
// Self-checking bench for the burst SRAM core
`default_nettype none
module test_pipelined_burst_sync_sram
    import pbss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic lin_n;
        pbss_addr_t a;
        logic [7:0] lo;
    } pbss_row_s;

    // Start address and the low bits of the four burst words
    localparam pbss_row_s ROWS [5] = '{
        '{1'b1, 18'h0_1231, 8'h4E}, '{1'b1, 18'h0_1232, 8'hB1},
        '{1'b1, 18'h0_1233, 8'hE4}, '{1'b0, 18'h0_1231, 8'h6C},
        '{1'b0, 18'h0_1233, 8'hC6}};

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic lin_n = 1'b1;
    logic oe_n = 1'b0;
    pbss_ctrl_s ctrl;
    pbss_addr_t addr;
    pbss_data_t dq_i;
    pbss_data_t dq_o;
    logic dq_oe;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    pbss_data_t w [6];
    logic [5:0] oe;

    always #4 mclk = ~mclk;

    pbss_core #(.DEPTH(PBSS_DEPTH)) dut (.mclk(mclk), .rst_b(rst_b),
        .ctrl(ctrl), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .output_en_n(oe_n), .burst_order_lin_n(lin_n));
    pbss_host host (.mclk(mclk), .ctrl(ctrl), .addr(addr), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe(dq_oe));

    task automatic chk_d(input string nm, input pbss_data_t exp,
                         input pbss_data_t got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_b(input string nm, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("Mismatches %0d in %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic pbss_data_t pat(input pbss_addr_t a);
        return 32'(a) ^ 32'hC3C3_0000;
    endfunction

    // Expected word of a burst step: upper bits fixed, low bits per row
    function automatic pbss_data_t exw(input pbss_row_s r, input int s);
        return pat({r.a[17:2], r.lo[7-2*s -: 2]});
    endfunction

    // Strap changes only under reset, then settles for three edges
    task automatic do_reset(input logic m);
        @(posedge mclk);
        rst_b <= 1'b0;
        lin_n <= m;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 1000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        do_reset(1'b1);
        // Global write with lane selects and enable inactive
        for (int k = 0; k < 4; k++) begin
            host.wr(18'h0_1230 + 18'(k), pat(18'h0_1230 + 18'(k)),
                    4'hF, 1'b1, 1'b0);
        end
        foreach (ROWS[r]) begin
            if (ROWS[r].lin_n !== lin_n) begin
                do_reset(ROWS[r].lin_n);
            end
            host.rd(ROWS[r].a, w, oe);
            for (int s = 0; s < 4; s++) begin
                chk_d("burst word", exw(ROWS[r], s), w[s]);
                chk_b("word drive", 1'b1, oe[s]);
            end
            chk_d("held word", exw(ROWS[r], 3), w[4]);
            chk_b("held drive", 1'b1, oe[4]);
            chk_b("released", 1'b0, oe[5]);
        end
        // Partial lane write, then lanes selected without the enable
        host.wr(18'h0_1232, 32'h1122_3344, 4'hA, 1'b0, 1'b1);
        host.wr(18'h0_1233, 32'hFFFF_FFFF, 4'h0, 1'b1, 1'b1);
        host.rd(18'h0_1232, w, oe);
        chk_d("lane write", (pat(18'h0_1232) & 32'hFF00_FF00)
              | 32'h0022_0044, w[0]);
        chk_d("no enable", pat(18'h0_1233), w[1]);
        chk_d("wrap word", pat(18'h0_1230), w[2]);
        // Output enable high: pins stay released, data still read
        @(posedge mclk);
        oe_n <= 1'b1;
        host.rd(18'h0_1231, w, oe);
        for (int s = 0; s < 6; s++) begin
            chk_b("oe released", 1'b0, oe[s]);
        end
        chk_d("word behind oe", pat(18'h0_1231), w[0]);
        end_sim();
    end
endmodule // test_pipelined_burst_sync_sram
`default_nettype wire
